// File: design/cfc_codec.sv
// Flag codec: captures each request flag byte, holds the decoded controls
// for the neighbouring blocks, and emits the response flag byte and error
// code as a byte stream. Assumes a single 25 MHz clock and that the frame
// deframer presents the first byte after SOF with i_req_first high.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns

module cfc_codec
#(
   parameter int FLAG_WIDTH = 8
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Request byte stream from the deframer
   input wire logic [7:0] i_req_byte,
   input wire logic i_req_valid,
   input wire logic i_req_first,
   // Tag context from neighbouring blocks
   input wire logic [1:0] i_tag_state,
   input wire logic i_uid_match,
   input wire logic i_uid_done,
   // Response request from command execution
   input wire logic i_rsp_start,
   input wire logic i_rsp_error,
   input wire logic [7:0] i_rsp_code,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Decoded controls
   output logic o_flags_valid,
   output logic o_two_subcarriers,
   output logic o_high_rate,
   output logic o_inventory,
   output logic o_extension,
   output logic o_option,
   output logic o_family_id_present,
   output logic o_uid_expected,
   output logic o_execute,
   output logic [3:0] o_slot_count_max,
   output logic [2:0] o_slot_bits,
   // Response byte stream
   output logic [7:0] o_rsp_byte,
   output logic o_rsp_valid,
   output logic o_rsp_last
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   if (FLAG_WIDTH != 8)
   begin : g_bad_width
      $error("cfc_codec: flag byte must be eight bits");
   end

   // ****************************************************************
   // Request flag capture
   // ****************************************************************
   logic [7:0] req_flags_reg;
   logic flags_valid_reg;
   logic [7:0] dec_src;
   logic d_sub, d_rate, d_inv, d_ext, d_sel, d_addr;
   logic d_fam, d_slot, d_opt, d_ferr;
   logic sw_override_reg;
   logic [7:0] sw_flags_reg;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         req_flags_reg <= cfc_pkg::RESET_BYTE;
         flags_valid_reg <= 1'b0;
      end
      else if (i_req_valid && i_req_first)
      begin
         req_flags_reg <= i_req_byte;
         flags_valid_reg <= 1'b1;
      end
   end

   // Software may force a flag byte for bring-up without a reader
   assign dec_src = sw_override_reg ? sw_flags_reg : req_flags_reg;

   cfc_flag_decode u_decode
   (
      .i_flags(dec_src),
      .o_two_subcarriers(d_sub),
      .o_high_rate(d_rate),
      .o_inventory(d_inv),
      .o_extension(d_ext),
      .o_select_only(d_sel),
      .o_uid_addressed(d_addr),
      .o_family_id_present(d_fam),
      .o_single_slot_bit(d_slot),
      .o_option(d_opt),
      .o_format_error(d_ferr)
   );

   // ****************************************************************
   // Execute decision
   // ****************************************************************
   logic execute_next;

   always_comb
   begin
      execute_next = 1'b1;
      if (d_ferr)
         execute_next = 1'b0;
      else if (d_sel)
         execute_next = (i_tag_state == cfc_pkg::TAG_SELECTED);
      else if (d_addr)
         execute_next = i_uid_done && i_uid_match;
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_flags_valid <= 1'b0;
         o_two_subcarriers <= 1'b0;
         o_high_rate <= 1'b0;
         o_inventory <= 1'b0;
         o_extension <= 1'b0;
         o_option <= 1'b0;
         o_family_id_present <= 1'b0;
         o_uid_expected <= 1'b0;
         o_execute <= 1'b0;
         o_slot_count_max <= 4'h0;
         o_slot_bits <= 3'h0;
      end
      else
      begin
         o_flags_valid <= flags_valid_reg || sw_override_reg;
         o_two_subcarriers <= d_sub;
         o_high_rate <= d_rate;
         o_inventory <= d_inv;
         o_extension <= d_ext;
         o_option <= d_opt;
         o_family_id_present <= d_fam;
         o_uid_expected <= d_addr;
         o_execute <= execute_next;
         // Non-inventory requests report single-slot figures
         if (d_inv && !d_slot)
         begin
            o_slot_count_max <= cfc_pkg::SLOT_COUNT_MANY;
            o_slot_bits <= cfc_pkg::SLOT_BITS_MANY;
         end
         else
         begin
            o_slot_count_max <= 4'h0;
            o_slot_bits <= 3'h0;
         end
      end
   end

   // ****************************************************************
   // Response flag and error code stream
   // ****************************************************************
   cfc_pkg::cfc_rsp_state_t rsp_state_reg;
   logic [7:0] rsp_flags_reg;
   logic [7:0] rsp_code_reg;
   logic [7:0] code_fix;

   // Unknown codes become the bad-command code on a format error, else the unspecified error code
   always_comb
   begin
      code_fix = cfc_pkg::ERR_UNSPECIFIED;
      if (i_rsp_code == cfc_pkg::ERR_BAD_COMMAND
          || i_rsp_code == cfc_pkg::ERR_NO_OPTION)
         code_fix = i_rsp_code;
      else if (d_ferr)
         code_fix = cfc_pkg::ERR_BAD_COMMAND;
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rsp_state_reg <= cfc_pkg::CFC_RSP_IDLE;
         rsp_flags_reg <= cfc_pkg::RESET_BYTE;
         rsp_code_reg <= cfc_pkg::RESET_BYTE;
      end
      else
      begin
         unique case (rsp_state_reg)
            cfc_pkg::CFC_RSP_IDLE:
            begin
               // A silent tag never starts a reply
               if (i_rsp_start && execute_next)
               begin
                  // Reserved bits and the extension bit stay zero
                  rsp_flags_reg <= cfc_pkg::RESET_BYTE;
                  rsp_flags_reg[cfc_pkg::RSP_ERROR] <= i_rsp_error;
                  rsp_code_reg <= code_fix;
                  rsp_state_reg <= cfc_pkg::CFC_RSP_FLAGS;
               end
            end
            cfc_pkg::CFC_RSP_FLAGS:
            begin
               if (rsp_flags_reg[cfc_pkg::RSP_ERROR])
                  rsp_state_reg <= cfc_pkg::CFC_RSP_CODE;
               else
                  rsp_state_reg <= cfc_pkg::CFC_RSP_IDLE;
            end
            cfc_pkg::CFC_RSP_CODE:
               rsp_state_reg <= cfc_pkg::CFC_RSP_IDLE;
            default:
               rsp_state_reg <= cfc_pkg::CFC_RSP_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rsp_byte <= 8'h00;
         o_rsp_valid <= 1'b0;
         o_rsp_last <= 1'b0;
      end
      else
      begin
         o_rsp_valid <= rsp_state_reg != cfc_pkg::CFC_RSP_IDLE;
         if (rsp_state_reg == cfc_pkg::CFC_RSP_CODE)
         begin
            o_rsp_byte <= rsp_code_reg;
            o_rsp_last <= 1'b1;
         end
         else if (rsp_state_reg == cfc_pkg::CFC_RSP_FLAGS)
         begin
            o_rsp_byte <= rsp_flags_reg;
            o_rsp_last <= !rsp_flags_reg[cfc_pkg::RSP_ERROR];
         end
         else
         begin
            o_rsp_byte <= 8'h00;
            o_rsp_last <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Register port
   // ****************************************************************
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sw_override_reg <= 1'b0;
         sw_flags_reg <= cfc_pkg::RESET_BYTE;
      end
      else if (i_wr && i_addr == cfc_pkg::ADDR_RSP_CTRL)
         sw_override_reg <= i_wdata[0];
      else if (i_wr && i_addr == cfc_pkg::ADDR_REQ_FLAGS)
         sw_flags_reg <= i_wdata;
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         unique case (i_addr)
            cfc_pkg::ADDR_REQ_FLAGS: o_rdata <= dec_src;
            cfc_pkg::ADDR_DECODE:
               o_rdata <= {d_ferr, d_slot, d_fam, d_addr,
                           d_sel, d_ext, d_rate, d_sub};
            cfc_pkg::ADDR_RSP_CTRL: o_rdata <= {7'h00, sw_override_reg};
            cfc_pkg::ADDR_RSP_FLAGS: o_rdata <= rsp_flags_reg;
            cfc_pkg::ADDR_TAG_STATE:
               o_rdata <= {5'h00, execute_next, i_tag_state};
            default: o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end

endmodule : cfc_codec

// File: design/cfc_flag_decode.sv
// Combinational decode of one request flag byte into named controls.
// Assumes the byte is held stable by the caller while it is read.
`timescale 1ns/1ns
module cfc_flag_decode
(
   // Request flag byte
   input wire logic [7:0] i_flags,
   // Decoded controls
   output logic o_two_subcarriers,
   output logic o_high_rate,
   output logic o_inventory,
   output logic o_extension,
   output logic o_select_only,
   output logic o_uid_addressed,
   output logic o_family_id_present,
   output logic o_single_slot_bit,
   output logic o_option,
   output logic o_format_error
);

   always_comb
   begin
      o_two_subcarriers = i_flags[cfc_pkg::REQ_SUBCARRIER];
      o_high_rate = i_flags[cfc_pkg::REQ_DATA_RATE];
      o_inventory = i_flags[cfc_pkg::REQ_INVENTORY];
      o_extension = i_flags[cfc_pkg::REQ_EXTENSION];
      o_option = i_flags[cfc_pkg::REQ_OPTION];
      // Meaning of bits 5 and 6 (indices 4 and 5) switches with the inventory bit
      o_select_only = !o_inventory
         && i_flags[cfc_pkg::REQ_SELECT_ONLY];
      o_uid_addressed = !o_inventory
         && i_flags[cfc_pkg::REQ_UID_ADDRESSED];
      o_family_id_present = o_inventory
         && i_flags[cfc_pkg::REQ_FAMILY_ID_PRESENT];
      o_single_slot_bit = o_inventory
         && i_flags[cfc_pkg::REQ_SINGLE_SLOT_BIT];
      // Select-only with a UID is contradictory from the reader
      o_format_error = o_select_only && o_uid_addressed;
   end

endmodule : cfc_flag_decode

// File: design/cfc_pkg.sv
// Constants for the contactless flag codec: flag bit positions, error codes,
// register offsets, reset values and reply field layout.
// Assumes the flag byte arrives already de-serialised, bit 1 in position 0.
package cfc_pkg;

   // ****************************************************************
   // Request flag positions (bit 1 of the byte is index 0)
   // ****************************************************************
   localparam int REQ_SUBCARRIER = 0;
   localparam int REQ_DATA_RATE = 1;
   localparam int REQ_INVENTORY = 2;
   localparam int REQ_EXTENSION = 3;
   localparam int REQ_SELECT_ONLY = 4;
   localparam int REQ_FAMILY_ID_PRESENT = 4;
   localparam int REQ_UID_ADDRESSED = 5;
   localparam int REQ_SINGLE_SLOT_BIT = 5;
   localparam int REQ_OPTION = 6;

   // ****************************************************************
   // Response flag positions and error codes
   // ****************************************************************
   localparam int RSP_ERROR = 0;
   localparam logic [7:0] ERR_BAD_COMMAND = 8'h02;
   localparam logic [7:0] ERR_NO_OPTION = 8'h03;
   localparam logic [7:0] ERR_UNSPECIFIED = 8'h0F;

   // ****************************************************************
   // Slot counter layout
   // ****************************************************************
   localparam logic [3:0] SLOT_COUNT_MANY = 4'hF;
   localparam logic [2:0] SLOT_BITS_MANY = 3'h4;

   // ****************************************************************
   // Register offsets and reset values
   // ****************************************************************
   localparam logic [3:0] ADDR_REQ_FLAGS = 4'h0;
   localparam logic [3:0] ADDR_DECODE = 4'h1;
   localparam logic [3:0] ADDR_RSP_CTRL = 4'h2;
   localparam logic [3:0] ADDR_RSP_FLAGS = 4'h3;
   localparam logic [3:0] ADDR_TAG_STATE = 4'h4;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ****************************************************************
   // Tag state encoding supplied by the neighbouring state machine
   // ****************************************************************
   localparam logic [1:0] TAG_READY = 2'h0;
   localparam logic [1:0] TAG_QUIET = 2'h1;
   localparam logic [1:0] TAG_SELECTED = 2'h2;

   typedef enum logic [2:0]
   {
      CFC_RSP_IDLE = 3'b001,
      CFC_RSP_FLAGS = 3'b010,
      CFC_RSP_CODE = 3'b100
   } cfc_rsp_state_t;

endpackage : cfc_pkg

// File: tb/cfc_codec_monitor.sv
// Checker for the flag codec: decode timing and reply byte stream.
// Assumes it is bound to cfc_codec and sees only its ports.
`timescale 1ns/1ns
module cfc_codec_monitor
(
   // Watched ports
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_req_byte,
   input wire logic i_req_valid,
   input wire logic i_req_first,
   input wire logic [1:0] i_tag_state,
   input wire logic i_rsp_start,
   input wire logic o_two_subcarriers,
   input wire logic o_high_rate,
   input wire logic o_family_id_present,
   input wire logic o_execute,
   input wire logic [3:0] o_slot_count_max,
   input wire logic [7:0] o_rsp_byte,
   input wire logic o_rsp_valid,
   input wire logic o_rsp_last
);
   // ****
   // Properties
   // ****
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // A lone flag byte, so the decode two edges on is its own
   sequence s_req;
      i_req_valid && i_req_first ##1 !(i_req_valid && i_req_first);
   endsequence
   sequence s_head;
      o_rsp_valid && !$past(o_rsp_valid);
   endsequence
   a_sub_decode: assert property (s_req |=>
      o_two_subcarriers == $past(i_req_byte[0], 2)) else $error("sub");
   a_rate_decode: assert property (s_req |=>
      o_high_rate == $past(i_req_byte[1], 2)) else $error("rate");
   a_family_decode: assert property (s_req |=> o_family_id_present ==
      ($past(i_req_byte[2], 2) && $past(i_req_byte[4], 2)))
      else $error("family");
   a_slot_decode: assert property (s_req |=> o_slot_count_max ==
      (($past(i_req_byte[2], 2) && !$past(i_req_byte[5], 2)) ? 4'hF : 4'h0))
      else $error("slot");
   a_select_exec: assert property ((i_req_valid && i_req_first &&
      !i_req_byte[2] && i_req_byte[4]) ##1 !(i_req_valid && i_req_first)
      |=> o_execute == (i_tag_state == cfc_pkg::TAG_SELECTED
      && !$past(i_req_byte[5], 2))) else $error("select");
   // The start edge is judged on the decision that o_execute shows next
   a_reply_cause: assert property (s_head |->
      $past(i_rsp_start, 2) && $past(o_execute, 1)) else $error("cause");
   a_flag_zeros: assert property (s_head |->
      o_rsp_byte[7:1] == 7'h00) else $error("reserved");
   a_error_code: assert property (s_head ##0 o_rsp_byte[0] |=>
      o_rsp_valid && o_rsp_last && o_rsp_byte inside {8'h02, 8'h03, 8'h0F})
      else $error("code");
endmodule : cfc_codec_monitor

bind cfc_codec cfc_codec_monitor u_cfc_codec_monitor (.i_clock, .i_rst_n,
   .i_req_byte, .i_req_valid, .i_req_first, .i_tag_state, .i_rsp_start,
   .o_two_subcarriers, .o_high_rate, .o_family_id_present, .o_execute,
   .o_slot_count_max, .o_rsp_byte, .o_rsp_valid, .o_rsp_last);

// File: tb/cfc_reader_model.sv
// Reader model: sends request frames into the codec one byte per cycle.
// Assumes a free-running clock shared with the codec.
`timescale 1ns/1ns
module cfc_reader_model
(
   // Clock
   input wire logic i_clock,
   // Request byte stream
   output logic [7:0] o_req_byte,
   output logic o_req_valid,
   output logic o_req_first
);
   // ****
   // Frame sender
   // ****
   initial
   begin
      o_req_byte = 8'h00;
      o_req_valid = 1'b0;
      o_req_first = 1'b0;
   end
   // Flag byte, then a command byte; bad keeps select with address
   task automatic send(input logic [7:0] flags, input logic bad);
      logic [7:0] f;
      f = flags;
      if (f[4] && !f[2] && !bad)
         f[5] = 1'b0;
      @(posedge i_clock);
      o_req_byte <= f;
      o_req_valid <= 1'b1;
      o_req_first <= 1'b1;
      @(posedge i_clock);
      o_req_byte <= 8'hA5;
      o_req_first <= 1'b0;
      @(posedge i_clock);
      o_req_valid <= 1'b0;
      // Released line shows the inverse so stale data cannot pass
      o_req_byte <= 8'h5A;
   endtask : send
endmodule : cfc_reader_model

// File: tb/tb_cfc_codec.sv
// Testbench for the flag codec: the reader model feeds requests, the bench
// drives tag context, replies and the register port and checks outputs.
`timescale 1ns/1ns
module tb_cfc_codec;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_req_byte;
   logic i_req_valid, i_req_first;
   logic [1:0] i_tag_state = cfc_pkg::TAG_READY;
   logic i_uid_match = 1'b0;
   logic i_uid_done = 1'b0;
   logic i_rsp_start = 1'b0;
   logic i_rsp_error = 1'b0;
   logic [7:0] i_rsp_code = 8'h00;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata, o_rsp_byte;
   logic o_flags_valid, o_two_subcarriers, o_high_rate, o_inventory;
   logic o_extension, o_option, o_family_id_present, o_uid_expected;
   logic o_execute, o_rsp_valid, o_rsp_last;
   logic [3:0] o_slot_count_max;
   logic [2:0] o_slot_bits;
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] fl [10] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40,
      8'h04, 8'h14, 8'h24, 8'h37};
   logic [7:0] ec [4] = '{8'h02, 8'h03, 8'h0F, 8'h10};
   logic [7:0] ex [4] = '{8'h02, 8'h03, 8'h0F, 8'h0F};

   always #20 i_clock = ~i_clock;

   cfc_codec u_cfc_codec (.i_clock, .i_rst_n, .i_req_byte, .i_req_valid,
      .i_req_first, .i_tag_state, .i_uid_match, .i_uid_done, .i_rsp_start,
      .i_rsp_error, .i_rsp_code, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_flags_valid, .o_two_subcarriers, .o_high_rate, .o_inventory,
      .o_extension, .o_option, .o_family_id_present, .o_uid_expected,
      .o_execute, .o_slot_count_max, .o_slot_bits, .o_rsp_byte,
      .o_rsp_valid, .o_rsp_last);
   cfc_reader_model u_cfc_reader_model (.i_clock, .o_req_byte(i_req_byte),
      .o_req_valid(i_req_valid), .o_req_first(i_req_first));

   // ****
   // Access and check tasks
   // ****
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : settle

   task automatic reply(input logic err, input logic [7:0] c, e,
      input logic live);
      @(posedge i_clock);
      i_rsp_start <= 1'b1;
      i_rsp_error <= err;
      i_rsp_code <= c;
      @(posedge i_clock);
      i_rsp_start <= 1'b0;
      settle(1);
      chk(o_rsp_valid, live);
      if (live)
      begin
         chk(o_rsp_byte, {7'h00, err});
         chk(o_rsp_last, !err);
      end
      settle(1);
      chk(o_rsp_valid, live & err);
      if (live & err)
      begin
         chk(o_rsp_byte, e);
         chk(o_rsp_last, 1'b1);
      end
   endtask : reply

   task test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // ****
   // Tests
   // ****
   initial
   begin
      #(40 * 3000);
      mismatches++;
      test_done;
   end

   initial
   begin
      repeat (12) @(posedge i_clock);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         u_cfc_reader_model.send(fl[i], 1'b0);
         settle(1);
         chk(o_flags_valid, 1'b1);
         chk(o_two_subcarriers, fl[i][0]);
         chk(o_high_rate, fl[i][1]);
         chk(o_inventory, fl[i][2]);
         chk(o_extension, fl[i][3]);
         chk(o_option, fl[i][6]);
         chk(o_family_id_present, fl[i][2] & fl[i][4]);
         chk(o_uid_expected, !fl[i][2] & fl[i][5]);
         chk(o_slot_count_max, (fl[i][2] & !fl[i][5]) ?
            cfc_pkg::SLOT_COUNT_MANY : 4'h0);
         chk(o_slot_bits, (fl[i][2] & !fl[i][5]) ?
            cfc_pkg::SLOT_BITS_MANY : 3'h0);
         rd(cfc_pkg::ADDR_REQ_FLAGS, fl[i]);
      end
      $display("test decode done");
      u_cfc_reader_model.send(8'h10, 1'b0);
      settle(1);
      chk(o_execute, 1'b0);
      reply(1'b0, 8'h00, 8'h00, 1'b0);
      i_tag_state <= cfc_pkg::TAG_SELECTED;
      u_cfc_reader_model.send(8'h10, 1'b0);
      settle(1);
      chk(o_execute, 1'b1);
      reply(1'b0, 8'h00, 8'h00, 1'b1);
      i_tag_state <= cfc_pkg::TAG_READY;
      i_uid_done <= 1'b1;
      u_cfc_reader_model.send(8'h20, 1'b0);
      settle(1);
      chk(o_execute, 1'b0);
      i_uid_match <= 1'b1;
      settle(2);
      chk(o_execute, 1'b1);
      u_cfc_reader_model.send(8'h30, 1'b1);
      settle(1);
      chk(o_execute, 1'b0);
      $display("test modes done");
      u_cfc_reader_model.send(8'h00, 1'b0);
      settle(1);
      for (int i = 0; i < 4; i++)
         reply(1'b1, ec[i], ex[i], 1'b1);
      $display("test reply done");
      wr(cfc_pkg::ADDR_REQ_FLAGS, 8'h02);
      wr(cfc_pkg::ADDR_RSP_CTRL, 8'h01);
      settle(3);
      chk(o_high_rate, 1'b1);
      rd(cfc_pkg::ADDR_REQ_FLAGS, 8'h02);
      rd(4'hF, 8'h00);
      rd(cfc_pkg::ADDR_DECODE, 8'h02);
      rd(cfc_pkg::ADDR_TAG_STATE, 8'h04);
      rd(cfc_pkg::ADDR_RSP_FLAGS, 8'h01);
      wr(cfc_pkg::ADDR_RSP_CTRL, 8'h00);
      $display("test registers done");
      test_done;
   end
endmodule : tb_cfc_codec
